/* src/rdsf_top.v */
// Purpose: mode/strap capture and status flags of a USB 2.0 redriver
// Assumes: line-state events arrive as decoded levels from the analog side
// Notes:   resetn_i is the device enable pin after board-level filtering
`timescale 1ns/100ps
`include "rdsf_regs.vh"
module rdsf_top (
  input  wire       clk_i,
  input  wire       resetn_i,
  input  wire       charger_port_enable_n_i,
  input  wire       sda_i,
  input  wire       scl_i,
  input  wire       sens_hi_i,
  input  wire       sens_lo_i,
  input  wire [1:0] boost_strap_i,
  input  wire       boost_float_i,
  input  wire [1:0] i2c_edge_boost_i,
  input  wire [1:0] i2c_dc_boost_i,
  input  wire       fixture_det_i,
  input  wire       test_packet_i,
  input  wire       usb_reset_i,
  input  wire       chirp_j_i,
  input  wire       chirp_k_i,
  input  wire       squelch_i,
  input  wire       pullup_det_i,
  input  wire       disconnect_i,
  input  wire       suspend_i,
  output reg        charger_en_o,
  output reg        i2c_mode_o,
  output wire [6:0] i2c_addr_o,
  output reg  [1:0] rx_sensitivity_o,
  output reg  [1:0] edge_boost_o,
  output reg  [1:0] dc_boost_o,
  output reg        straps_valid_o,
  output wire       sens_pin_o,
  output wire       sens_pin_oe_o,
  output wire       scl_pin_o,
  output wire       scl_pin_oe_o,
  output reg        high_speed_active_flag_o,
  output reg        attach_detect_flag_o,
  output wire       active_o
);
  localparam ST_IDLE  = 3'h0;
  localparam ST_FIXT  = 3'h1;
  localparam ST_CHJ   = 3'h2;
  localparam ST_CHK   = 3'h3;
  localparam ST_HSOK  = 3'h4;
  localparam ST_HS    = 3'h5;
  localparam MIN_CYC  = `RDSF_CHIRP_MIN_CYC;
  localparam MAX_CYC  = `RDSF_CHIRP_MAX_CYC;

  wire [15:0] sy;
  reg  [2:0]  st_r;
  reg  [2:0]  st_nxt;
  reg  [`RDSF_CNT_W-1:0] cnt_r;
  reg  captured_r;
  reg  prev_j_r;
  reg  prev_k_r;

  // Single-bit pin-side inputs are resynchronised before use; boost_strap_i and the I2C boost buses are not
  rdsf_sync #(.W(16)) u_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .d_i      ({charger_port_enable_n_i, sda_i, scl_i, sens_hi_i,
                sens_lo_i, fixture_det_i, test_packet_i, usb_reset_i,
                chirp_j_i, chirp_k_i, squelch_i, pullup_det_i,
                disconnect_i, suspend_i, boost_float_i, 1'b0}),
    .q_o      (sy)
  );
  wire cpe_n  = sy[15];
  wire sda_s  = sy[14];
  wire scl_s  = sy[13];
  wire shi_s  = sy[12];
  wire slo_s  = sy[11];
  wire fix_s  = sy[10];
  wire tpk_s  = sy[9];
  wire urst_s = sy[8];
  wire cj_s   = sy[7];
  wire ck_s   = sy[6];
  wire sq_s   = sy[5];
  wire pu_s   = sy[4];
  wire dis_s  = sy[3];
  wire sus_s  = sy[2];
  wire bfl_s  = sy[1];

  // Synchroniser resets to zero; its filter needs four edges to pass a
  // steady pin, so capture waits seven edges after release
  reg [2:0] settle_r;
  assign active_o   = resetn_i;
  assign i2c_addr_o = `RDSF_I2C_ADDR;

  function [1:0] decode_sens;
    input hi;
    input lo;
    begin
      if (hi && !lo) begin
        decode_sens = `RDSF_SENS_HIGH;
      end else if (lo && !hi) begin
        decode_sens = `RDSF_SENS_LOW;
      end else begin
        decode_sens = `RDSF_SENS_MED;
      end
    end
  endfunction

  // Straps caught once after release; held until next reset, except boosts, which follow the I2C inputs in I2C mode
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      settle_r         <= 3'h0;
      captured_r       <= 1'b0;
      straps_valid_o   <= 1'b0;
      i2c_mode_o       <= 1'b0;
      rx_sensitivity_o <= `RDSF_SENS_MED;
      edge_boost_o     <= `RDSF_BOOST_FLOAT;
      dc_boost_o       <= `RDSF_BOOST_FLOAT;
    end else if (!captured_r) begin
      if (settle_r != 3'h6) begin
        settle_r <= settle_r + 3'h1;
      end else begin
        captured_r       <= 1'b1;
        straps_valid_o   <= 1'b1;
        i2c_mode_o       <= sda_s & scl_s;
        rx_sensitivity_o <= decode_sens(shi_s, slo_s);
        if (bfl_s) begin
          edge_boost_o <= `RDSF_BOOST_FLOAT;
          dc_boost_o   <= `RDSF_BOOST_FLOAT;
        end else begin
          edge_boost_o <= boost_strap_i;
          dc_boost_o   <= boost_strap_i;
        end
      end
    end else if (i2c_mode_o) begin
      edge_boost_o <= i2c_edge_boost_i;
      dc_boost_o   <= i2c_dc_boost_i;
    end
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      charger_en_o <= 1'b0;
    end else begin
      charger_en_o <= ~cpe_n & straps_valid_o;
    end
  end

  // Chirp length check; counter saturates to avoid wrap
  wire chirp_ok = (cnt_r >= MIN_CYC) && (cnt_r <= MAX_CYC);

  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (fix_s) begin
          st_nxt = ST_FIXT;
        end else if (urst_s && cj_s) begin
          st_nxt = ST_CHJ;
        end
      end
      ST_FIXT: begin
        if (tpk_s) begin
          st_nxt = ST_HS;
        end else if (!fix_s) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_CHJ: begin
        if (!cj_s) begin
          st_nxt = (ck_s && chirp_ok) ? ST_CHK : ST_IDLE;
        end
      end
      ST_CHK: begin
        if (!ck_s) begin
          st_nxt = chirp_ok ? ST_HSOK : ST_IDLE;
        end
      end
      ST_HSOK: begin
        if (sq_s) begin
          st_nxt = ST_HS;
        end
      end
      ST_HS: begin
        if (dis_s || (urst_s && !sus_s)) begin
          st_nxt = ST_IDLE;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
    // Disconnect aborts any handshake in progress
    if (dis_s) begin
      st_nxt = ST_IDLE;
    end
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r     <= ST_IDLE;
      cnt_r    <= {`RDSF_CNT_W{1'b0}};
      prev_j_r <= 1'b0;
      prev_k_r <= 1'b0;
      high_speed_active_flag_o <= 1'b0;
      attach_detect_flag_o     <= 1'b0;
    end else if (captured_r) begin
      st_r     <= st_nxt;
      prev_j_r <= cj_s;
      prev_k_r <= ck_s;
      if ((cj_s && !prev_j_r) || (ck_s && !prev_k_r)) begin
        cnt_r <= {`RDSF_CNT_W{1'b0}};
      end else if (cnt_r != {`RDSF_CNT_W{1'b1}}) begin
        cnt_r <= cnt_r + {{(`RDSF_CNT_W-1){1'b0}}, 1'b1};
      end
      high_speed_active_flag_o <= (st_nxt == ST_HS);
      if (dis_s) begin
        attach_detect_flag_o <= 1'b0;
      end else if (pu_s) begin
        attach_detect_flag_o <= 1'b1;
      end
    end
  end

  // Flag pins only driven in strap mode after capture
  assign sens_pin_oe_o = captured_r & ~i2c_mode_o;
  assign sens_pin_o    = high_speed_active_flag_o;
  assign scl_pin_oe_o  = captured_r & ~i2c_mode_o;
  assign scl_pin_o     = attach_detect_flag_o;
endmodule

/* src/rdsf_regs.vh */
// Purpose: constants for the redriver strap and status flag logic
// Assumes: 25 MHz clock
// Notes:   times in ns, cycle counts derived from them
`ifndef RDSF_REGS_VH
`define RDSF_REGS_VH
`define RDSF_CLK_PERIOD_NS   40
`define RDSF_I2C_ADDR        7'h2C
`define RDSF_SENS_LOW        2'h0
`define RDSF_SENS_MED        2'h1
`define RDSF_SENS_HIGH       2'h2
`define RDSF_BOOST_FLOAT     2'h3
`define RDSF_CHIRP_MIN_NS    18000
`define RDSF_CHIRP_MAX_NS    128000
`define RDSF_CHIRP_MIN_CYC   ((`RDSF_CHIRP_MIN_NS + `RDSF_CLK_PERIOD_NS - 1) / `RDSF_CLK_PERIOD_NS)
`define RDSF_CHIRP_MAX_CYC   (`RDSF_CHIRP_MAX_NS / `RDSF_CLK_PERIOD_NS)
`define RDSF_CNT_W           13
`endif

/* src/rdsf_sync.v */
// Purpose: three-stage synchroniser with agreement filter
// Assumes: async inputs, one clock
// Notes:   output changes once stages two and three agree
`timescale 1ns/100ps
module rdsf_sync #(
  parameter W = 1
) (
  input  wire         clk_i,
  input  wire         resetn_i,
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] q_o
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : bit_g
      always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          s1_r[g] <= 1'b0;
          s2_r[g] <= 1'b0;
          s3_r[g] <= 1'b0;
          q_o[g]  <= 1'b0;
        end else begin
          s1_r[g] <= d_i[g];
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
          // Single-cycle glitches between stages are ignored
          if (s2_r[g] == s3_r[g]) begin
            q_o[g] <= s3_r[g];
          end
        end
      end
    end
  endgenerate
endmodule

/* verif/rdsf_props.sv */
// Purpose: port assertions for rdsf_top
// Assumes: straps steady from reset release to capture
// Notes:   bound to every rdsf_top instance
`timescale 1ns/100ps
module rdsf_props (
  input wire       clk_i, resetn_i, charger_port_enable_n_i, sda_i, scl_i,
  input wire       pullup_det_i, disconnect_i, test_packet_i, squelch_i,
  input wire       charger_en_o, i2c_mode_o, straps_valid_o, sens_pin_o,
  input wire       sens_pin_oe_o, scl_pin_o, scl_pin_oe_o,
  input wire       high_speed_active_flag_o, attach_detect_flag_o,
  input wire [1:0] rx_sensitivity_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // Six cycles clear the three-flop synchroniser and its filter
  sequence s_attached;
    (pullup_det_i && !disconnect_i && straps_valid_o) [*6];
  endsequence
  sequence s_gone;
    disconnect_i [*6];
  endsequence
  a_charger_off: assert property (
    charger_port_enable_n_i [*8] |=> !charger_en_o) else $error("charger on");
  a_straps_hold: assert property (
    straps_valid_o && $past(straps_valid_o) |->
    $stable(rx_sensitivity_o) && $stable(i2c_mode_o)) else $error("strap moved");
  a_flag_pins: assert property (
    sens_pin_oe_o == (straps_valid_o && !i2c_mode_o) &&
    scl_pin_oe_o == sens_pin_oe_o && (!sens_pin_oe_o ||
    (sens_pin_o == high_speed_active_flag_o &&
    scl_pin_o == attach_detect_flag_o))) else $error("flag pin wrong");
  a_attach_set: assert property (s_attached |=> attach_detect_flag_o)
    else $error("attach not set");
  a_attach_clear: assert property (s_gone |=> !attach_detect_flag_o)
    else $error("attach not cleared");
  a_hs_cause: assert property (
    $rose(high_speed_active_flag_o) |-> test_packet_i || squelch_i)
    else $error("hs without cause");
  a_capture_time: assert property (
    $rose(resetn_i) |-> !straps_valid_o ##[4:8] straps_valid_o)
    else $error("capture late");
  a_mode_pick: assert property (
    $rose(straps_valid_o) |-> i2c_mode_o == (sda_i && scl_i))
    else $error("mode wrong");
endmodule
bind rdsf_top rdsf_props rdsf_props_i (.*);

/* verif/rdsf_usb_peer.sv */
// Purpose: USB line-state peer feeding decoded events
// Assumes: levels change just after a rising edge
// Notes:   all low is an unconnected, silent cable
`timescale 1ns/100ps
module rdsf_usb_peer (
  input  wire clk_i,
  output reg  fixture_det_i = 1'b0,
  output reg  test_packet_i = 1'b0,
  output reg  usb_reset_i = 1'b0,
  output reg  chirp_j_i = 1'b0,
  output reg  chirp_k_i = 1'b0,
  output reg  squelch_i = 1'b0,
  output reg  pullup_det_i = 1'b0,
  output reg  disconnect_i = 1'b0
);
  // One call sets every level, then holds it n cycles
  task drive(input [7:0] v, input integer n);
    @(posedge clk_i);
    {fixture_det_i, test_packet_i, usb_reset_i, chirp_j_i, chirp_k_i,
     squelch_i, pullup_det_i, disconnect_i} <= v;
    repeat (n) @(posedge clk_i);
  endtask
endmodule

/* verif/rdsf_top_bench.sv */
// Purpose: self-checking bench for rdsf_top
// Assumes: peer model supplies line-state events
// Notes:   ten-cycle waits cover the input synchroniser
`timescale 1ns/100ps
module rdsf_top_bench;
  reg        clk_i = 1'b0, resetn_i = 1'b0, charger_port_enable_n_i = 1'b1;
  reg        sda_i = 1'b0, scl_i = 1'b0, sens_hi_i = 1'b0, sens_lo_i = 1'b0;
  reg        boost_float_i = 1'b0, suspend_i = 1'b0;
  reg  [1:0] boost_strap_i = 2'h0, i2c_edge_boost_i = 2'h1, i2c_dc_boost_i = 2'h2;
  reg  [7:0] e;
  wire       fixture_det_i, test_packet_i, usb_reset_i, chirp_j_i, chirp_k_i;
  wire       squelch_i, pullup_det_i, disconnect_i, charger_en_o, i2c_mode_o;
  wire       straps_valid_o, sens_pin_o, sens_pin_oe_o, scl_pin_o, active_o;
  wire       scl_pin_oe_o, high_speed_active_flag_o, attach_detect_flag_o;
  wire [6:0] i2c_addr_o;
  wire [1:0] rx_sensitivity_o, edge_boost_o, dc_boost_o;
  integer    err_count = 0, checks_done = 0, cyc = 0, i;
  rdsf_top      rdsf_top_i (.*);
  rdsf_usb_peer rdsf_usb_peer_i (.*);
  always #20 clk_i = ~clk_i;
  // Run is near 5000 cycles; the ceiling leaves twice that
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (cyc == 10000) begin err_count = err_count + 1; report_and_stop; end
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string nm, input [15:0] seen, input [15:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Checks sit on the falling edge, clear of register updates
  task w(input integer n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task rst(input [6:0] v);
    @(posedge clk_i);
    resetn_i <= 1'b0;
    {sda_i, scl_i, sens_hi_i, sens_lo_i, boost_float_i, boost_strap_i} <= v;
    w(18);
    chk("reset", {active_o, rx_sensitivity_o, edge_boost_o,
        straps_valid_o}, 8'h0E);
    @(posedge clk_i);
    resetn_i <= 1'b1;
    w(12);
    chk("mode", {straps_valid_o, i2c_mode_o}, {6'h01, v[6] & v[5]});
  endtask
  task hs(input integer nj, input integer nk, input [7:0] x);
    rdsf_usb_peer_i.drive(8'h22, 10);
    rdsf_usb_peer_i.drive(8'h32, nj);
    rdsf_usb_peer_i.drive(8'h2A, nk);
    rdsf_usb_peer_i.drive(8'h02, 10);
    rdsf_usb_peer_i.drive(8'h06, 12);
    rdsf_usb_peer_i.drive(8'h02, 0);
    w(1);
    chk("hs", high_speed_active_flag_o, x);
  endtask
  initial begin
    for (i = 0; i < 4; i = i + 1) begin
      rst({i[0], 1'b0, i[1:0], i == 3, (i == 3) ? 2'h0 : i[1:0]});
      e = (i == 2) ? 8'h02 : (i == 1) ? 8'h00 : 8'h01;
      chk("strap", {sens_pin_oe_o, scl_pin_oe_o, rx_sensitivity_o,
          edge_boost_o, dc_boost_o}, {2'h3, e[1:0], i[1:0], i[1:0]});
      @(posedge clk_i);
      {sda_i, scl_i, sens_hi_i, sens_lo_i, boost_strap_i} <= 6'h3D;
      w(10);
      chk("held", {i2c_mode_o, rx_sensitivity_o}, e);
      $display("test strap %0d done", i);
    end
    rst(7'h60);
    chk("addr", i2c_addr_o, 8'h2C);
    chk("i2c", {sens_pin_oe_o, scl_pin_oe_o, edge_boost_o}, 8'h01);
    @(posedge clk_i);
    i2c_dc_boost_i <= 2'h0;
    charger_port_enable_n_i <= 1'b0;
    w(10);
    chk("live", {charger_en_o, dc_boost_o}, 8'h04);
    @(posedge clk_i);
    charger_port_enable_n_i <= 1'b1;
    w(10);
    chk("charger", charger_en_o, 8'h00);
    $display("test i2c done");
    rst(7'h00);
    rdsf_usb_peer_i.drive(8'h80, 10);
    rdsf_usb_peer_i.drive(8'hC0, 12);
    rdsf_usb_peer_i.drive(8'h00, 0);
    w(1);
    chk("fixture", {high_speed_active_flag_o, sens_pin_o}, 8'h03);
    rdsf_usb_peer_i.drive(8'h01, 10);
    rdsf_usb_peer_i.drive(8'h02, 10);
    w(1);
    chk("attach", {high_speed_active_flag_o, attach_detect_flag_o,
        scl_pin_o}, 8'h03);
    hs(300, 300, 8'h00);
    hs(450, 3200, 8'h01);
    rdsf_usb_peer_i.drive(8'h01, 10);
    w(1);
    chk("detach", {attach_detect_flag_o, scl_pin_o}, 8'h00);
    $display("test flags done");
    report_and_stop;
  end
endmodule
